// file: core/swp_supervisor.sv
// Supervisor port: watchdog, power-fail monitor and RS485 line mode
// How it works
// - Watchdog disabled after every system reset
// - First write of bit0 one enables watchdog
// - Missed refresh produces processor reset pulse
// - Permit strap required; otherwise watchdog stays off
// - Power failure drives channel check NMI
// - Power monitor strap open suppresses NMI
// - Port read returns power-fail status on D3
// - Status reads zero when input low
// - Reset selects full duplex RS485
// - Bit3 selects party line, direction follows RTS
// - Shared transceiver receives after reset
`timescale 1ns/10ps
`default_nettype none
`include "swp_cfg.svh"
module swp_supervisor
  import swp_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = `SWP_WD_TIMEOUT_CYC,
  parameter int unsigned PULSE_CYC   = `SWP_RST_PULSE_CYC
)(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Host I/O port
  input  wire swp_io_req_t io_req,
  output var  logic [7:0]  io_rdata_q,
  // Straps and detector (asynchronous pins)
  input  wire logic        watchdog_permit_strap,
  input  wire logic        power_monitor_strap,
  input  wire logic        power_fail_n,
  // System outputs
  output var  logic        wd_reset_q,
  output var  logic        chck_nmi_q,
  // RS485 on the secondary serial port
  input  wire logic        uart_rts,
  output var  logic        party_line_q,
  output var  logic        xcvr_drive_q
);

  // Pin synchronisers; every pin is asynchronous to the system clock
  logic [1:0]    permit_sync_q;    // Strap synchroniser
  logic [1:0]    pmon_sync_q;      // Strap synchroniser
  logic [1:0]    pf_sync_q;        // Detector synchroniser
  logic [1:0]    rts_sync_q;       // RTS synchroniser
  // Watchdog timing state
  swp_wd_state_t wd_state_q;       // Watchdog state
  logic          refresh_bit_q;    // Last written refresh value
  logic [31:0]   wd_count_q;       // Cycles since last refresh
  logic [31:0]   pulse_count_q;    // Reset pulse length counter
  // Port decode results
  logic          hit_wr;           // Write to the supervisor port
  logic          hit_rd;           // Read of the supervisor port
  logic          refresh;          // Refresh accepted this cycle

  // Address decode shared by read and write
  function automatic logic port_hit(input logic [9:0] a);
    port_hit = (a == `SWP_PORT_ADDR);
  endfunction : port_hit

  // Full ten-bit decode, so aliases of the port stay silent
  assign hit_wr  = io_req.wr & port_hit(io_req.addr);
  assign hit_rd  = io_req.rd & port_hit(io_req.addr);
  // A rewrite of the same value is no proof of life
  assign refresh = hit_wr &&
    (io_req.wdata[`SWP_BIT_WD_REFRESH] != refresh_bit_q);

  // Two-stage synchronisers; only the second stage is read
  // The detector stage resets to good so reset raises no NMI
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      permit_sync_q <= 2'h0;
      pmon_sync_q   <= 2'h0;
      pf_sync_q     <= 2'h3;
      rts_sync_q    <= 2'h0;
    end
    else
    begin
      // Shift the pins in; stage one feeds nothing but stage two
      permit_sync_q <= {permit_sync_q[0], watchdog_permit_strap};
      pmon_sync_q   <= {pmon_sync_q[0], power_monitor_strap};
      pf_sync_q     <= {pf_sync_q[0], power_fail_n};
      rts_sync_q    <= {rts_sync_q[0], uart_rts};
    end
  end

  // Refresh bit readback value
  // Every port write stores bit 1, changed or not; comparing a
  // write against this copy is what makes it a refresh
  always_ff @(posedge clock)
  begin
    if (rst)
      refresh_bit_q <= 1'b0;
    else if (hit_wr)
      refresh_bit_q <= io_req.wdata[`SWP_BIT_WD_REFRESH];
  end

  // Watchdog state machine
  always_ff @(posedge clock)
  begin
    if (rst)
      wd_state_q <= SWP_WD_OFF;
    else
    begin
      unique case (wd_state_q)
        SWP_WD_OFF:
        begin
          // Enable only with the permit strap fitted
          if (hit_wr && io_req.wdata[`SWP_BIT_WD_EN] &&
              permit_sync_q[1])
            wd_state_q <= SWP_WD_RUN;
        end
        SWP_WD_RUN:
        begin
          // Pulling the strap disarms a running watchdog too
          if (!permit_sync_q[1])
            wd_state_q <= SWP_WD_OFF;
          // A refresh in the very last counted cycle still saves it
          else if (!refresh && wd_count_q >= TIMEOUT_CYC - 1)
            wd_state_q <= SWP_WD_FIRE;
        end
        SWP_WD_FIRE:
        begin
          // Hold the firing state for the whole pulse
          if (pulse_count_q >= PULSE_CYC - 1)
            wd_state_q <= SWP_WD_OFF;
        end
        // Code 3 is never entered; fall back to the safe state
        default:
          wd_state_q <= SWP_WD_OFF;
      endcase
    end
  end

  // Timeout counter, cleared on each real refresh
  // 32 bits hold the full timeout at the system clock rate
  always_ff @(posedge clock)
  begin
    if (rst || wd_state_q != SWP_WD_RUN || refresh)
      wd_count_q <= 32'h0;
    else
      wd_count_q <= wd_count_q + 32'h1;
  end

  // Reset pulse counter and output
  // The output is registered, so it trails the state by one
  // cycle and stands one cycle less than the firing state
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pulse_count_q <= 32'h0;
      wd_reset_q    <= 1'b0;
    end
    else
    begin
      wd_reset_q    <= (wd_state_q == SWP_WD_FIRE) &&
                       (pulse_count_q < PULSE_CYC - 1);
      if (wd_state_q == SWP_WD_FIRE)
        pulse_count_q <= pulse_count_q + 32'h1;
      else
        pulse_count_q <= 32'h0;
    end
  end

  // NMI from power failure, gated by the monitor strap
  // Level output: it follows the detector while the strap is
  // closed, so nothing here needs clearing by software
  always_ff @(posedge clock)
  begin
    if (rst)
      chck_nmi_q <= 1'b0;
    else
      chck_nmi_q <= pmon_sync_q[1] & ~pf_sync_q[1];
  end

  // Party line select and transceiver direction
  // Every port write carries the mode bit, so software must keep
  // bit 3 set in its refresh writes to stay on the party line
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      party_line_q <= 1'b0;
      xcvr_drive_q <= 1'b0;
    end
    else
    begin
      if (hit_wr)
        party_line_q <= io_req.wdata[`SWP_BIT_PARTY];
      // Direction uses the new mode so the line follows at once
      xcvr_drive_q <= (hit_wr ? io_req.wdata[`SWP_BIT_PARTY]
                              : party_line_q) & rts_sync_q[1];
    end
  end

  // Registered read data; one cycle after the read strobe
  // Bit 3 shows the detector, not the line mode, so the mode
  // written there cannot be read back
  always_ff @(posedge clock)
  begin
    if (rst)
      io_rdata_q <= 8'h00;
    else if (hit_rd)
    begin
      io_rdata_q <= 8'h00;
      io_rdata_q[`SWP_BIT_WD_EN]      <= (wd_state_q != SWP_WD_OFF);
      io_rdata_q[`SWP_BIT_WD_REFRESH] <= refresh_bit_q;
      io_rdata_q[`SWP_BIT_PF_STATUS]  <= pf_sync_q[1];
    end
    // Outside a read the data lines rest at zero
    else
      io_rdata_q <= 8'h00;
  end

endmodule : swp_supervisor
`default_nettype wire

// file: core/swp_cfg.svh
// Constants for the supervisor port: address, bit positions, timing
`ifndef SWP_CFG_SVH
`define SWP_CFG_SVH
`define SWP_PORT_ADDR      10'h201
`define SWP_BIT_WD_EN      0
`define SWP_BIT_WD_REFRESH 1
`define SWP_BIT_PF_STATUS  3
`define SWP_BIT_PARTY      3
`define SWP_CLK_HZ         10000000
`define SWP_WD_TIMEOUT_MS  1600
`define SWP_WD_TIMEOUT_CYC ((`SWP_CLK_HZ / 1000) * `SWP_WD_TIMEOUT_MS)
`define SWP_RST_PULSE_CYC  16
`endif

// file: core/swp_pkg.sv
// Types shared by the supervisor port logic
package swp_pkg;
  // Host I/O request as seen at the port decoder
  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } swp_io_req_t;
  // Watchdog states
  typedef enum logic [1:0] {
    SWP_WD_OFF,
    SWP_WD_RUN,
    SWP_WD_FIRE
  } swp_wd_state_t;
endpackage : swp_pkg

// file: testbench/swp_monitor.sv
// Checker on the supervisor port pins
`timescale 1ns/10ps
`default_nettype none
module swp_monitor
  import swp_pkg::*;
#(parameter int unsigned PULSE_CYC = 16)(
  // Clock, reset and host port
  input wire logic clock,
  input wire logic rst,
  input wire swp_io_req_t io_req,
  input wire logic [7:0] io_rdata_q,
  // Pins
  input wire logic watchdog_permit_strap,
  input wire logic power_monitor_strap,
  input wire logic power_fail_n,
  input wire logic uart_rts,
  // Outputs
  input wire logic wd_reset_q,
  input wire logic chck_nmi_q,
  input wire logic party_line_q,
  input wire logic xcvr_drive_q
);
  logic [7:0] hi_q; // Cycles the reset pulse has stood
  logic hit; // Access aimed at the port
  assign hit = io_req.addr == 10'h201;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Saturates so a stuck pulse still fails the length check
  always_ff @(posedge clock)
    if (rst || !wd_reset_q) hi_q <= 8'h00;
    else if (hi_q != 8'hFF) hi_q <= hi_q + 8'h01;
  a_reset_quiet: assert property (disable iff (1'b0) rst |=>
    !(wd_reset_q | chck_nmi_q | party_line_q | xcvr_drive_q))
    else $error("rst");
  a_party_write: assert property (io_req.wr && hit |=>
    party_line_q == $past(io_req.wdata[3])) else $error("party");
  a_read_idle: assert property (!(io_req.rd && hit) |=>
    io_rdata_q == 8'h00) else $error("rdata");
  a_pulse_len: assert property ($fell(wd_reset_q) |->
    hi_q == PULSE_CYC - 1) else $error("pulse");
  a_permit_off: assert property (!watchdog_permit_strap [*8] |=>
    !$rose(wd_reset_q)) else $error("permit");
  a_nmi_strap: assert property (!power_monitor_strap [*5] |->
    !chck_nmi_q) else $error("strap");
  a_nmi_good: assert property (power_fail_n [*5] |->
    !chck_nmi_q) else $error("nmi");
  a_drive_rts: assert property (!uart_rts [*4] |->
    !xcvr_drive_q) else $error("drive");
  c_fire: cover property ($rose(wd_reset_q));
  c_nmi: cover property ($rose(chck_nmi_q));
  c_drive: cover property ($rose(xcvr_drive_q));
endmodule : swp_monitor
bind swp_supervisor swp_monitor #(.PULSE_CYC(PULSE_CYC)) u_mon (
  .clock                 (clock),
  .rst                   (rst),
  .io_req                (io_req),
  .io_rdata_q            (io_rdata_q),
  .watchdog_permit_strap (watchdog_permit_strap),
  .power_monitor_strap   (power_monitor_strap),
  .power_fail_n          (power_fail_n),
  .uart_rts              (uart_rts),
  .wd_reset_q            (wd_reset_q),
  .chck_nmi_q            (chck_nmi_q),
  .party_line_q          (party_line_q),
  .xcvr_drive_q          (xcvr_drive_q)
);
`default_nettype wire

// file: testbench/swp_host_model.sv
// Host software model issuing single-byte port cycles
`timescale 1ns/10ps
`default_nettype none
module swp_host_model
  import swp_pkg::*;
(
  // Port bus
  input wire logic clock,
  output var swp_io_req_t io_req,
  input wire logic [7:0] io_rdata_q,
  output var logic [7:0] seen
);
  initial io_req = '0;
  // One read or write cycle per call, then the read data is sampled
  task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge clock) io_req <= '{a, d, w, !w};
    // Released lines show the inverse so stale values never match
    @(posedge clock) io_req <= '{~a, ~d, 1'b0, 1'b0};
    #1 seen = io_rdata_q;
  endtask : acc
endmodule : swp_host_model
`default_nettype wire

// file: testbench/supervisor_watchdog_powerfail_tb.sv
// Self-checking bench for the supervisor port
`timescale 1ns/10ps
`default_nettype none
module supervisor_watchdog_powerfail_tb;
  import swp_pkg::*;
  logic clock = 0, rst = 1, watchdog_permit_strap = 0, uart_rts = 0;
  logic power_monitor_strap = 0, power_fail_n = 1;
  logic wd_reset_q, chck_nmi_q, party_line_q, xcvr_drive_q;
  logic [7:0] io_rdata_q, seen;
  swp_io_req_t io_req;
  int num_errors = 0, cmp_count = 0, on = 0, rf = 0, n;
  always #50 clock = ~clock;
  swp_supervisor #(.TIMEOUT_CYC(50), .PULSE_CYC(16)) DUT (.*);
  swp_host_model HOST (.*);
  task chk(input string s, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s exp %h seen %h", s, e, g);
    end
  endtask : chk
  task tick(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask : tick
  // Model: enabling needs the permit strap, every port write stores bit1
  task wr(input logic [9:0] a, input logic [7:0] d);
    HOST.acc(1'b1, a, d);
    if (a == 10'h201 && watchdog_permit_strap) on = on | d[0];
    if (a == 10'h201) rf = d[1];
  endtask : wr
  task rd(input logic [7:0] m);
    HOST.acc(1'b0, 10'h201, 8'h00);
    chk("port", (power_fail_n * 8 + rf * 2 + on) & m, seen & m);
  endtask : rd
  task report_and_stop;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop
  initial
  begin
    #200000 num_errors++;
    report_and_stop();
  end
  initial
  begin
    n = $urandom(32'hD1E92CB2);
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    tick(3);
    chk("outs", 8'h00, {wd_reset_q, chck_nmi_q});
    chk("mode", 8'h00, {party_line_q, xcvr_drive_q});
    rd(8'hFF);
    wr(10'h202, 8'h0B);
    rd(8'hFF);
    wr(10'h201, 8'h09);
    @(posedge clock) uart_rts <= 1'b1;
    tick(4);
    chk("drive", 8'h03, {party_line_q, xcvr_drive_q});
    @(posedge clock) uart_rts <= 1'b0;
    tick(4);
    chk("drive", 8'h02, {party_line_q, xcvr_drive_q});
    rd(8'hFF);
    @(posedge clock) watchdog_permit_strap <= 1'b1;
    tick(4);
    for (n = 0; n < 6; n++)
    begin
      wr(10'h201, n[0] ? 8'h01 : 8'h03);
      tick(40);
      chk("early", 8'h00, wd_reset_q);
    end
    rd(8'hFF);
    wr(10'h201, 8'h01);
    for (n = 0; n < 40 && wd_reset_q !== 1'b1; n++) tick(1);
    chk("fire", 8'h01, n < 15);
    for (n = 0; n < 40 && wd_reset_q === 1'b1; n++) tick(1);
    chk("pulse", 8'h0F, n);
    on = 0;
    rd(8'h01);
    wr(10'h201, 8'h09);
    @(posedge clock) rst <= 1'b1;
    @(posedge clock) rst <= 1'b0;
    tick(3);
    on = 0;
    rf = 0;
    rd(8'hFF);
    chk("mode", 8'h00, {party_line_q, xcvr_drive_q});
    repeat (8)
    begin
      @(posedge clock) power_monitor_strap <= ($urandom & 1) != 0;
      power_fail_n <= ($urandom & 1) != 0;
      tick(6);
      n = power_monitor_strap & ~power_fail_n;
      chk("nmi", n, chck_nmi_q);
      rd(8'h08);
    end
    report_and_stop();
  end
endmodule : supervisor_watchdog_powerfail_tb
`default_nettype wire
